// ### design/trig_io.sv
/*
 * trigger inputs and result outputs of a fixed-mount scanner core.
 * assumes isolated trigger pins, a decode engine on CLOCK that reports
 * results as one-cycle pulses, and a simple register port.
 */
// Contract
// - each trigger has debounce and polarity none/rise/fall/low/high; resets none.
// - triggers start decoding only in one-shot, burst or continuous mode.
// - low level in continuous mode decodes while low, stops when high.
// - level-triggered window also ends on a successful read.
// - falling edge starts decoding; stops on timeout or good read.
// - each output selects off, always on, good read or no read; resets off.
// - good-read output fires only when all selected codes decoded.
// - no-read output fires when triggered codes were not decoded.
// - an asserted output stays on for a programmable duration, default 100ms.
// - output asserts after a programmable delay, default 100ms.
`timescale 1ns/1ps
module trig_io import trig_io_pkg::*; #(
    parameter int CNT_W = 32,
    parameter int DEB_W = 24,
    parameter logic [31:0] DLY_RESET = 32'(DLY_DEFAULT_CYC),
    parameter logic [31:0] DUR_RESET = 32'(DUR_DEFAULT_CYC),
    parameter logic [31:0] DEB_RESET = 32'(DEBOUNCE_DEFAULT_CYC)
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // isolated trigger pins
    input wire logic [1:0] TRIG_IN,
    // decode engine
    input wire logic GOOD_READ,
    input wire logic NO_READ,
    input wire logic READ_TIMEOUT,
    output logic DECODE_EN,
    // result outputs and interrupt
    output logic [1:0] RESULT_OUT,
    output logic IRQ
);
    // ****************************************************************
    // registers
    // ****************************************************************
    op_mode_e op_mode;
    logic [7:0] in_cfg;
    logic [7:0] out_cfg;
    logic [DEB_W-1:0] deb_period;
    logic [CNT_W-1:0] out_dly [2];
    logic [CNT_W-1:0] out_dur [2];
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    op_mode_e next_op_mode;
    logic [7:0] next_in_cfg;
    logic [7:0] next_out_cfg;
    logic [DEB_W-1:0] next_deb_period;
    logic [CNT_W-1:0] next_out_dly [2];
    logic [CNT_W-1:0] next_out_dur [2];
    logic [IRQ_W-1:0] next_irq_stat;
    logic [IRQ_W-1:0] next_irq_mask;
    logic [31:0] next_rdata;
    logic next_irq;

    reg_req_s req;
    result_s result;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] level;
    logic [1:0] level_d;
    logic [1:0] out_active;
    logic [1:0] out_fired;
    logic decoding;
    logic next_decoding;
    logic start_ev;
    logic stop_ev;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign result = '{good: GOOD_READ, no_read: NO_READ,
                      timeout: READ_TIMEOUT};

    function automatic polarity_e pol_of(input logic [7:0] cfg,
                                         input int idx);
        logic [POL_W-1:0] f;
        f = (idx == 0) ? cfg[POL_W-1:0]
                       : cfg[IN2_POL_LSB +: POL_W];
        return (f > 3'(POL_HIGH)) ? POL_NONE : polarity_e'(f);
    endfunction

    // ****************************************************************
    // register access
    // ****************************************************************
    always_comb begin
        next_op_mode = op_mode;
        next_in_cfg = in_cfg;
        next_out_cfg = out_cfg;
        next_deb_period = deb_period;
        next_out_dly = out_dly;
        next_out_dur = out_dur;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_rdata = 32'h0000_0000;
        if (req.wr) begin
            case (req.addr)
                REG_MODE: next_op_mode = op_mode_e'(req.wdata[1:0]);
                REG_IN_CFG: next_in_cfg = req.wdata[7:0];
                REG_OUT_CFG: next_out_cfg = req.wdata[7:0];
                REG_DEBOUNCE: next_deb_period = req.wdata[DEB_W-1:0];
                REG_OUT1_DLY: next_out_dly[0] = req.wdata[CNT_W-1:0];
                REG_OUT1_DUR: next_out_dur[0] = req.wdata[CNT_W-1:0];
                REG_OUT2_DLY: next_out_dly[1] = req.wdata[CNT_W-1:0];
                REG_OUT2_DUR: next_out_dur[1] = req.wdata[CNT_W-1:0];
                REG_IRQ_STAT:
                    next_irq_stat = irq_stat & ~req.wdata[IRQ_W-1:0];
                REG_IRQ_MASK: next_irq_mask = req.wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        next_irq_stat[IRQ_START] = next_irq_stat[IRQ_START] | start_ev;
        next_irq_stat[IRQ_STOP] = next_irq_stat[IRQ_STOP] | stop_ev;
        next_irq_stat[IRQ_OUT1] = next_irq_stat[IRQ_OUT1] | out_fired[0];
        next_irq_stat[IRQ_OUT2] = next_irq_stat[IRQ_OUT2] | out_fired[1];
        if (req.rd) begin
            case (req.addr)
                REG_MODE: next_rdata = {30'h0000_0000, op_mode};
                REG_IN_CFG: next_rdata = {24'h00_0000, in_cfg};
                REG_OUT_CFG: next_rdata = {24'h00_0000, out_cfg};
                REG_DEBOUNCE: next_rdata = 32'(deb_period);
                REG_OUT1_DLY: next_rdata = 32'(out_dly[0]);
                REG_OUT1_DUR: next_rdata = 32'(out_dur[0]);
                REG_OUT2_DLY: next_rdata = 32'(out_dly[1]);
                REG_OUT2_DUR: next_rdata = 32'(out_dur[1]);
                REG_STATUS: next_rdata = {27'h000_0000, decoding,
                                          out_active, level};
                REG_IRQ_STAT: next_rdata = 32'(irq_stat);
                REG_IRQ_MASK: next_rdata = 32'(irq_mask);
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            op_mode <= MODE_MANUAL;
            in_cfg <= 8'h00;
            out_cfg <= 8'h00;
            deb_period <= DEB_RESET[DEB_W-1:0];
            out_dly <= '{DLY_RESET[CNT_W-1:0], DLY_RESET[CNT_W-1:0]};
            out_dur <= '{DUR_RESET[CNT_W-1:0], DUR_RESET[CNT_W-1:0]};
            irq_stat <= '0;
            irq_mask <= '0;
            RDATA <= 32'h0000_0000;
            IRQ <= 1'b0;
        end else begin
            op_mode <= next_op_mode;
            in_cfg <= next_in_cfg;
            out_cfg <= next_out_cfg;
            deb_period <= next_deb_period;
            out_dly <= next_out_dly;
            out_dur <= next_out_dur;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            RDATA <= next_rdata;
            IRQ <= next_irq;
        end
    end

    // ****************************************************************
    // trigger inputs
    // ****************************************************************
    // pins are asynchronous; only sync2 feeds logic
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 2'b11;
            sync2 <= 2'b11;
            level_d <= 2'b11;
        end else begin
            sync1 <= TRIG_IN;
            sync2 <= sync1;
            level_d <= level;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            debounce #(.CNT_W(DEB_W)) u_deb (
                .clk(CLOCK),
                .rst_n(RST_N),
                .period(deb_period),
                .level_in(sync2[gi]),
                .level_out(level[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // decode window
    // ****************************************************************
    always_comb begin
        logic ext_mode;
        logic starting;
        logic level_stop;
        polarity_e p;
        ext_mode = 1'b0;
        starting = 1'b0;
        level_stop = 1'b0;
        p = POL_NONE;
        next_decoding = decoding;
        ext_mode = (op_mode != MODE_MANUAL);
        for (int i = 0; i < 2; i++) begin
            p = pol_of(in_cfg, i);
            case (p)
                POL_RISE: starting |= level[i] & ~level_d[i];
                POL_FALL: starting |= ~level[i] & level_d[i];
                POL_LOW: begin
                    starting |= ~level[i] & level_d[i];
                    level_stop |= level[i] & ~level_d[i];
                end
                POL_HIGH: begin
                    starting |= level[i] & ~level_d[i];
                    level_stop |= ~level[i] & level_d[i];
                end
                default: ;
            endcase
        end
        starting &= ext_mode;
        if (!decoding && starting) begin
            next_decoding = 1'b1;
        end else if (decoding && (result.good || result.timeout
                                  || result.no_read || level_stop
                                  || !ext_mode)) begin
            next_decoding = 1'b0;
        end
        start_ev = !decoding && next_decoding;
        stop_ev = decoding && !next_decoding;
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            decoding <= 1'b0;
        end else begin
            decoding <= next_decoding;
        end
    end

    // ****************************************************************
    // result outputs
    // ****************************************************************
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            out_pulse #(.CNT_W(CNT_W)) u_out (
                .clk(CLOCK),
                .rst_n(RST_N),
                .sel(out_event_e'(out_cfg[gi*OUT2_EVT_LSB +: EVT_W])),
                .delay(out_dly[gi]),
                .duration(out_dur[gi]),
                .result(result),
                .active(out_active[gi]),
                .fired(out_fired[gi])
            );
        end
    endgenerate

    assign DECODE_EN = decoding;
    assign RESULT_OUT = out_active;
endmodule // trig_io

// ### design/trig_io_pkg.sv
/*
 * shared constants and carriers for the trigger input / result output block.
 * assumes a 100 MHz system clock and the plain register port of the core.
 */
package trig_io_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int DUR_DEFAULT_MS = 100;
    localparam int DLY_DEFAULT_MS = 100;
    localparam int DEBOUNCE_DEFAULT_MS = 2;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int DUR_DEFAULT_CYC = DUR_DEFAULT_MS * CYC_PER_MS;
    localparam int DLY_DEFAULT_CYC = DLY_DEFAULT_MS * CYC_PER_MS;
    localparam int DEBOUNCE_DEFAULT_CYC = DEBOUNCE_DEFAULT_MS * CYC_PER_MS;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_IN_CFG = 8'h04;
    localparam logic [7:0] REG_OUT_CFG = 8'h08;
    localparam logic [7:0] REG_DEBOUNCE = 8'h0C;
    localparam logic [7:0] REG_OUT1_DLY = 8'h10;
    localparam logic [7:0] REG_OUT1_DUR = 8'h14;
    localparam logic [7:0] REG_OUT2_DLY = 8'h18;
    localparam logic [7:0] REG_OUT2_DUR = 8'h1C;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_IRQ_STAT = 8'h24;
    localparam logic [7:0] REG_IRQ_MASK = 8'h28;

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int POL_W = 3;
    localparam int IN2_POL_LSB = 4;
    localparam int EVT_W = 2;
    localparam int OUT2_EVT_LSB = 4;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam int IRQ_W = 4;
    // irq bits: 0 start, 1 stop, 2 out1 fired, 3 out2 fired
    localparam int IRQ_START = 0;
    localparam int IRQ_STOP = 1;
    localparam int IRQ_OUT1 = 2;
    localparam int IRQ_OUT2 = 3;

    // ****************************************************************
    // enumerations
    // ****************************************************************
    typedef enum logic [2:0] {
        POL_NONE, POL_RISE, POL_FALL, POL_LOW, POL_HIGH
    } polarity_e;

    typedef enum logic [1:0] {
        MODE_MANUAL, MODE_ONESHOT, MODE_BURST, MODE_CONT
    } op_mode_e;

    typedef enum logic [1:0] {
        EVT_OFF, EVT_ALWAYS, EVT_GOOD, EVT_NOREAD
    } out_event_e;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic good;
        logic no_read;
        logic timeout;
    } result_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// ### design/debounce.sv
/*
 * debounce filter for one synchronised trigger level.
 * assumes the input has already passed a two flip-flop synchroniser.
 */
`timescale 1ns/1ps
module debounce import trig_io_pkg::*; #(
    parameter int CNT_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filter period and data
    input wire logic [CNT_W-1:0] period,
    input wire logic level_in,
    output logic level_out
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_level_out;

    // ****************************************************************
    // filter
    // ****************************************************************
    always_comb begin
        next_count = '0;
        next_level_out = level_out;
        if (level_in != level_out) begin
            if (count >= period) begin
                next_level_out = level_in;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            // idle high like the synchroniser: no false edge after reset
            level_out <= 1'b1;
        end else begin
            count <= next_count;
            level_out <= next_level_out;
        end
    end
endmodule // debounce

// ### design/out_pulse.sv
/*
 * delayed, timed pulse for one result output.
 * assumes one-cycle event pulses from the same clock domain.
 */
`timescale 1ns/1ps
module out_pulse import trig_io_pkg::*; #(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire out_event_e sel,
    input wire logic [CNT_W-1:0] delay,
    input wire logic [CNT_W-1:0] duration,
    // results
    input wire result_s result,
    // output
    output logic active,
    output logic fired
);
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ON} pulse_e;
    pulse_e state;
    pulse_e next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic next_active;
    logic next_fired;
    logic trig;

    always_comb begin
        case (sel)
            EVT_GOOD: trig = result.good;
            EVT_NOREAD: trig = result.no_read;
            default: trig = 1'b0;
        endcase
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_count = count;
        next_active = 1'b0;
        next_fired = 1'b0;
        case (state)
            ST_IDLE: begin
                if (trig) begin
                    next_state = ST_WAIT;
                    next_count = '0;
                end
            end
            ST_WAIT: begin
                if (count + 1'b1 >= delay) begin
                    next_state = ST_ON;
                    next_count = '0;
                    next_active = 1'b1;
                    next_fired = 1'b1;
                end else begin
                    next_count = count + 1'b1;
                end
            end
            ST_ON: begin
                if (count + 1'b1 >= duration) begin
                    next_state = ST_IDLE;
                end else begin
                    next_count = count + 1'b1;
                    next_active = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (sel == EVT_OFF) begin
            next_state = ST_IDLE;
            next_active = 1'b0;
        end else if (sel == EVT_ALWAYS) begin
            next_state = ST_IDLE;
            next_active = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            count <= '0;
            active <= 1'b0;
            fired <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            active <= next_active;
            fired <= next_fired;
        end
    end
endmodule // out_pulse

// ### test/trig_io_properties.sv
/* checker on the trig_io ports: decode window and output 1 timing.
   assumes output 1 keeps its reset delay and duration, good read only. */
`timescale 1ns/1ps
module trig_io_properties import trig_io_pkg::*; #(
    parameter logic [31:0] DLY_RESET = 32'h0000_0005,
    parameter logic [31:0] DUR_RESET = 32'h0000_0005
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // watched ports
    input wire logic WR,
    input wire logic [1:0] TRIG_IN,
    input wire logic GOOD_READ,
    input wire logic NO_READ,
    input wire logic READ_TIMEOUT,
    input wire logic DECODE_EN,
    input wire logic [1:0] RESULT_OUT
);
    localparam int OUT_LAT = int'(DLY_RESET) + 1;
    logic wrote;
    logic next_wrote;
    logic [31:0] hi_cnt;
    logic [31:0] next_hi_cnt;
    // length of the current output 1 pulse
    always_comb begin
        next_wrote = wrote | WR;
        next_hi_cnt = RESULT_OUT[0] ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            wrote <= 1'h0;
            hi_cnt <= 32'h0000_0000;
        end else begin
            wrote <= next_wrote;
            hi_cnt <= next_hi_cnt;
        end
    end
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    AST_IDLE_DECODE: assert property (!wrote |-> !DECODE_EN)
        else $error("decode window open before setup");
    AST_IDLE_OUT: assert property (!wrote |-> RESULT_OUT == 2'h0)
        else $error("output active before setup");
    AST_DEBOUNCE: assert property ($rose(DECODE_EN) |->
        $past(TRIG_IN, 4) == $past(TRIG_IN, 5) &&
        $past(TRIG_IN, 5) == $past(TRIG_IN, 6))
        else $error("decode started on an unsettled pin");
    AST_GOOD_STOP: assert property (DECODE_EN && GOOD_READ |=> !DECODE_EN)
        else $error("good read did not end the window");
    AST_TIMEOUT_STOP: assert property (
        DECODE_EN && READ_TIMEOUT |=> !DECODE_EN)
        else $error("timeout did not end the window");
    AST_NOREAD_STOP: assert property (DECODE_EN && NO_READ |=> !DECODE_EN)
        else $error("no read did not end the window");
    AST_OUT_DELAY: assert property (
        $rose(RESULT_OUT[0]) |-> $past(GOOD_READ, OUT_LAT))
        else $error("output 1 rose off its delay");
    AST_OUT_DURATION: assert property (
        $fell(RESULT_OUT[0]) |-> hi_cnt == DUR_RESET)
        else $error("output 1 pulse length wrong");
endmodule // trig_io_properties

bind trig_io trig_io_properties #(
    .DLY_RESET(DLY_RESET),
    .DUR_RESET(DUR_RESET)
) trig_io_properties_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .WR(WR), .TRIG_IN(TRIG_IN),
    .GOOD_READ(GOOD_READ), .NO_READ(NO_READ), .READ_TIMEOUT(READ_TIMEOUT),
    .DECODE_EN(DECODE_EN), .RESULT_OUT(RESULT_OUT)
);

// ### test/trig_sensor.sv
/* model of the trigger sensors on the isolated pins.
   assumes commands change just after a rising clock edge. */
`timescale 1ns/1ps
module trig_sensor (
    // clock
    input wire logic clk,
    // commanded behaviour
    input wire logic [1:0] level,
    input wire logic [1:0] glitch,
    input wire logic bouncy,
    // pins
    output logic [1:0] pin
);
    logic [1:0] last = 2'h3;
    logic [1:0] moved = 2'h0;
    logic [2:0] chat = 3'h0;
    // real contacts chatter for a few cycles after each change
    always @(posedge clk) begin
        if (level != last) begin
            last <= level;
            moved <= level ^ last;
            chat <= bouncy ? 3'h4 : 3'h0;
        end else if (chat != 3'h0) begin
            chat <= chat - 3'h1;
        end
    end
    assign pin = level ^ glitch ^ ({2{chat[0]}} & moved);
endmodule // trig_sensor

// ### test/test_trig_io.sv
/* self-checking bench for trig_io with a trigger sensor model.
   assumes shortened delay, duration and debounce counts. */
`timescale 1ns/1ps
module test_trig_io import trig_io_pkg::*; ;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    localparam int OUT2_DLY = 2;
    typedef struct packed {
        out_event_e sel;
        logic [2:0] cause;
        logic [3:0] exp;
    } row_s;
    // out2 selection, event {good, no read, timeout}, out2 at 4 moments
    row_s rows [7] = '{'{EVT_OFF, 3'h4, 4'h0}, '{EVT_GOOD, 3'h4, 4'h6},
        '{EVT_GOOD, 3'h2, 4'h0}, '{EVT_NOREAD, 3'h2, 4'h6},
        '{EVT_NOREAD, 3'h4, 4'h0}, '{EVT_ALWAYS, 3'h0, 4'hF},
        '{EVT_OFF, 3'h2, 4'h0}};
    logic clock, rst_n, wr, rd, decode_en, irq, bouncy;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [2:0] ev;
    logic [1:0] trig_in, result_out, level, glitch;
    int n_errors = 0;
    int samples_checked = 0;

    trig_io #(.DLY_RESET(32'h0000_0005), .DUR_RESET(32'h0000_0005),
        .DEB_RESET(32'h0000_0003)) trig_io_inst (
        .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .TRIG_IN(trig_in), .GOOD_READ(ev[2]),
        .NO_READ(ev[1]), .READ_TIMEOUT(ev[0]), .DECODE_EN(decode_en),
        .RESULT_OUT(result_out), .IRQ(irq));
    trig_sensor trig_sensor_inst (.clk(clock), .level(level),
        .glitch(glitch), .bouncy(bouncy), .pin(trig_in));

    task automatic check1(input string what, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check32(input string what, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        rd <= 1'h1;
        addr <= a;
        @(posedge clock);
        rd <= 1'h0;
        @(negedge clock);
        d = rdata;
    endtask
    task automatic pulse(input logic [2:0] c);
        @(posedge clock);
        ev <= c;
        @(posedge clock);
        ev <= 3'h0;
    endtask
    task automatic drive_pin(input logic [1:0] v);
        @(posedge clock);
        level <= v;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wait_de(input logic v, input string what);
        int i;
        i = 0;
        while (decode_en !== v && i < 40) begin
            @(negedge clock);
            i++;
        end
        check1(what, v, decode_en);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // whole run is near 500 cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        final_report();
    end

    initial begin
        rst_n = 1'h0;
        {wr, rd, bouncy} = 3'h0;
        addr = 8'h00;
        wdata = ZERO;
        ev = 3'h0;
        level = 2'h3;
        glitch = 2'h0;
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        cycles(1);
        check32("outputs", ZERO, 32'({decode_en, result_out}));
        reg_rd(REG_IN_CFG, rv);
        check32("in_cfg", ZERO, rv);
        reg_rd(REG_OUT_CFG, rv);
        check32("out_cfg", ZERO, rv);
        reg_rd(8'h3C, rv);
        check32("unmapped", ZERO, rv);
        reg_wr(REG_OUT2_DLY, 32'(OUT2_DLY));
        reg_wr(REG_OUT2_DUR, 32'h0000_0003);
        foreach (rows[i]) begin
            reg_wr(REG_OUT_CFG, 32'({rows[i].sel, 2'h0, EVT_GOOD}));
            pulse(rows[i].cause);
            cycles(OUT2_DLY);
            check1("out2 wait", rows[i].exp[3], result_out[1]);
            cycles(1);
            check1("out2 rise", rows[i].exp[2], result_out[1]);
            cycles(2);
            check1("out2 held", rows[i].exp[1], result_out[1]);
            cycles(1);
            check1("out2 end", rows[i].exp[0], result_out[1]);
            cycles(12);
        end
        // falling edge on input 1 in every mode
        reg_wr(REG_IN_CFG, 32'h0000_0002);
        for (int m = 0; m < 4; m++) begin
            reg_wr(REG_MODE, 32'(m));
            drive_pin(2'h2);
            cycles(15);
            check1("edge start", 1'(m != 0), decode_en);
            pulse(3'h1);
            cycles(1);
            check1("timeout stop", 1'h0, decode_en);
            drive_pin(2'h3);
            cycles(15);
        end
        // low level with a bouncing contact
        bouncy = 1'h1;
        reg_wr(REG_IN_CFG, 32'h0000_0003);
        drive_pin(2'h2);
        wait_de(1'h1, "level start");
        pulse(3'h4);
        cycles(1);
        check1("good stop", 1'h0, decode_en);
        drive_pin(2'h3);
        cycles(15);
        drive_pin(2'h2);
        wait_de(1'h1, "level again");
        drive_pin(2'h3);
        wait_de(1'h0, "level release");
        bouncy = 1'h0;
        // rising edge on input 2 mirrors the falling edge
        reg_wr(REG_IN_CFG, 32'h0000_0010);
        drive_pin(2'h1);
        cycles(15);
        check1("rise idle", 1'h0, decode_en);
        drive_pin(2'h3);
        wait_de(1'h1, "rise start");
        pulse(3'h2);
        cycles(1);
        check1("no read stop", 1'h0, decode_en);
        // a two-cycle disturbance must not start decoding
        reg_wr(REG_IN_CFG, 32'h0000_0002);
        @(posedge clock);
        glitch <= 2'h1;
        repeat (2) @(posedge clock);
        glitch <= 2'h0;
        cycles(15);
        check1("glitch ignored", 1'h0, decode_en);
        // high level on input 2 mirrors the low level
        reg_wr(REG_IN_CFG, 32'h0000_0040);
        drive_pin(2'h1);
        cycles(15);
        check1("high idle", 1'h0, decode_en);
        drive_pin(2'h3);
        wait_de(1'h1, "high start");
        reg_rd(REG_STATUS, rv);
        check32("status", 32'h0000_0013, rv);
        drive_pin(2'h1);
        wait_de(1'h0, "high release");
        // interrupt mask and clear of the start event
        reg_wr(REG_IRQ_MASK, ZERO);
        cycles(3);
        check1("irq masked", 1'h0, irq);
        reg_wr(REG_IRQ_MASK, 32'h0000_0001);
        cycles(3);
        check1("irq raised", 1'h1, irq);
        reg_wr(REG_IRQ_STAT, 32'h0000_0001);
        cycles(3);
        check1("irq cleared", 1'h0, irq);
        // reset in mid-run brings back polarity none and output off
        @(posedge clock);
        rst_n <= 1'h0;
        repeat (2) @(posedge clock);
        rst_n <= 1'h1;
        cycles(1);
        check32("rst outputs", ZERO, 32'({decode_en, result_out, irq}));
        reg_rd(REG_IN_CFG, rv);
        check32("in_cfg reset", ZERO, rv);
        reg_rd(REG_OUT_CFG, rv);
        check32("out_cfg reset", ZERO, rv);
        final_report();
    end
endmodule // test_trig_io
